/* rtl/pes_counter.v */
// one programmable event counter with wrap pulse
`timescale 1ns/10ps
`include "pes_defs.vh"

module pes_counter (
    input wire sys_clk_i,
    input wire srst_i,
    input wire en_i,
    input wire clr_i,
    input wire [`PES_INC_W-1:0] inc_i,
    output reg [`PES_CNT_W-1:0] val_o,
    output reg wrap_o
);

wire [`PES_CNT_W:0] sum;

assign sum = {1'b0, val_o} + {{(`PES_CNT_W-`PES_INC_W+1){1'b0}}, inc_i};

always @(posedge sys_clk_i) begin
    if (srst_i) begin
        val_o <= 32'h0000_0000;
        wrap_o <= 1'b0;
    end else if (clr_i) begin
        val_o <= 32'h0000_0000;
        wrap_o <= 1'b0;
    end else if (en_i) begin
        val_o <= sum[`PES_CNT_W-1:0];
        wrap_o <= sum[`PES_CNT_W];
    end else begin
        wrap_o <= 1'b0;
    end
end

endmodule

/* rtl/pes_defs.vh */
// constants for the processing element performance event sources
`ifndef PES_DEFS_VH
`define PES_DEFS_VH

// ****************************************
// sizes
// ****************************************
`define PES_NUM_CNT 6
`define PES_CNT_W 32
`define PES_CYC_W 64
`define PES_EVN_W 16
`define PES_INC_W 3
`define PES_IDX_W 6
`define PES_NUM_PULSE 31
`define PES_NUM_SRC 41
`define PES_SLOTS 3'h4
`define PES_SLOTS_W 4

// ****************************************
// source index of the level and count events
// ****************************************
`define PES_IX_CYCLES 6'h1f
`define PES_IX_STALL_FE 6'h20
`define PES_IX_STALL_BE 6'h21
`define PES_IX_STALL_ANY 6'h22
`define PES_IX_STALL_MEM 6'h23
`define PES_IX_UOP_DONE 6'h24
`define PES_IX_UOP_SPEC 6'h25
`define PES_IX_SLOT_BE 6'h26
`define PES_IX_SLOT_FE 6'h27
`define PES_IX_SLOT_ANY 6'h28

// ****************************************
// event numbers, pulse sources in index order 0 to 30
// ****************************************
`define PES_EVN_INSTR_DONE 16'h0008
`define PES_EVN_L1_DC_ACC 16'h0004
`define PES_EVN_MEM_ACC 16'h0013
`define PES_EVN_L1_IC_ACC 16'h0014
`define PES_EVN_L2_DC_ACC 16'h0016
`define PES_EVN_L2_IC_ACC 16'h0027
`define PES_EVN_L3_DC_ACC 16'h002b
`define PES_EVN_LAST_RD 16'h0036
`define PES_EVN_LAST_RD_MISS 16'h0037
`define PES_EVN_L1_DRD_SLOW 16'h0039
`define PES_EVN_L1_DC_RD 16'h0040
`define PES_EVN_L2_DC_RD 16'h0050
`define PES_EVN_MEM_RD 16'h0066
`define PES_EVN_L3_DC_RD 16'h00a0
`define PES_EVN_L1_IF_SLOW 16'h4006
`define PES_EVN_L2_DRD_SLOW 16'h4009
`define PES_EVN_L2_IF_SLOW 16'h400a
`define PES_EVN_L3_DRD_SLOW 16'h400b
`define PES_EVN_L1_DX_ACC 16'h0025
`define PES_EVN_L1_IX_ACC 16'h0026
`define PES_EVN_D_WALK 16'h0034
`define PES_EVN_I_WALK 16'h0035
`define PES_EVN_L1_DX_DEM 16'h8130
`define PES_EVN_L1_IX_DEM 16'h8131
`define PES_EVN_D_WALK_DEM 16'h813c
`define PES_EVN_I_WALK_DEM 16'h813d
`define PES_EVN_L1_DC_DEM 16'h8140
`define PES_EVN_L1_IC_DEM 16'h8141
`define PES_EVN_L2_DC_DEM 16'h8148
`define PES_EVN_L2_IC_DEM 16'h8149
`define PES_EVN_L3_DC_DEM 16'h8150

// ****************************************
// event numbers, level and count sources
// ****************************************
`define PES_EVN_CYCLES 16'h0011
`define PES_EVN_STALL_FE 16'h0023
`define PES_EVN_STALL_BE 16'h0024
`define PES_EVN_STALL_ANY 16'h003c
`define PES_EVN_STALL_MEM 16'h4005
`define PES_EVN_UOP_DONE 16'h003a
`define PES_EVN_UOP_SPEC 16'h003b
`define PES_EVN_SLOT_BE 16'h003d
`define PES_EVN_SLOT_FE 16'h003e
`define PES_EVN_SLOT_ANY 16'h003f

`endif

/* rtl/pes_evt_sel.v */
// event number decode and increment select for one counter
`timescale 1ns/10ps
`include "pes_defs.vh"

module pes_evt_sel (
    input wire [`PES_EVN_W-1:0] evt_num_i,
    input wire [`PES_NUM_SRC*`PES_INC_W-1:0] src_inc_i,
    output reg [`PES_INC_W-1:0] inc_o,
    output reg known_o
);

// ****************************************
// event number to source index, msb flags a known number
// ****************************************
function [`PES_IDX_W:0] pes_evt_index;
    input [`PES_EVN_W-1:0] num;
    begin
        case (num)
            `PES_EVN_INSTR_DONE: pes_evt_index = 7'h40;
            `PES_EVN_L1_DC_ACC: pes_evt_index = 7'h41;
            `PES_EVN_MEM_ACC: pes_evt_index = 7'h42;
            `PES_EVN_L1_IC_ACC: pes_evt_index = 7'h43;
            `PES_EVN_L2_DC_ACC: pes_evt_index = 7'h44;
            `PES_EVN_L2_IC_ACC: pes_evt_index = 7'h45;
            `PES_EVN_L3_DC_ACC: pes_evt_index = 7'h46;
            `PES_EVN_LAST_RD: pes_evt_index = 7'h47;
            `PES_EVN_LAST_RD_MISS: pes_evt_index = 7'h48;
            `PES_EVN_L1_DRD_SLOW: pes_evt_index = 7'h49;
            `PES_EVN_L1_DC_RD: pes_evt_index = 7'h4a;
            `PES_EVN_L2_DC_RD: pes_evt_index = 7'h4b;
            `PES_EVN_MEM_RD: pes_evt_index = 7'h4c;
            `PES_EVN_L3_DC_RD: pes_evt_index = 7'h4d;
            `PES_EVN_L1_IF_SLOW: pes_evt_index = 7'h4e;
            `PES_EVN_L2_DRD_SLOW: pes_evt_index = 7'h4f;
            `PES_EVN_L2_IF_SLOW: pes_evt_index = 7'h50;
            `PES_EVN_L3_DRD_SLOW: pes_evt_index = 7'h51;
            `PES_EVN_L1_DX_ACC: pes_evt_index = 7'h52;
            `PES_EVN_L1_IX_ACC: pes_evt_index = 7'h53;
            `PES_EVN_D_WALK: pes_evt_index = 7'h54;
            `PES_EVN_I_WALK: pes_evt_index = 7'h55;
            `PES_EVN_L1_DX_DEM: pes_evt_index = 7'h56;
            `PES_EVN_L1_IX_DEM: pes_evt_index = 7'h57;
            `PES_EVN_D_WALK_DEM: pes_evt_index = 7'h58;
            `PES_EVN_I_WALK_DEM: pes_evt_index = 7'h59;
            `PES_EVN_L1_DC_DEM: pes_evt_index = 7'h5a;
            `PES_EVN_L1_IC_DEM: pes_evt_index = 7'h5b;
            `PES_EVN_L2_DC_DEM: pes_evt_index = 7'h5c;
            `PES_EVN_L2_IC_DEM: pes_evt_index = 7'h5d;
            `PES_EVN_L3_DC_DEM: pes_evt_index = 7'h5e;
            `PES_EVN_CYCLES: pes_evt_index = {1'b1, `PES_IX_CYCLES};
            `PES_EVN_STALL_FE: pes_evt_index = {1'b1, `PES_IX_STALL_FE};
            `PES_EVN_STALL_BE: pes_evt_index = {1'b1, `PES_IX_STALL_BE};
            `PES_EVN_STALL_ANY: pes_evt_index = {1'b1, `PES_IX_STALL_ANY};
            `PES_EVN_STALL_MEM: pes_evt_index = {1'b1, `PES_IX_STALL_MEM};
            `PES_EVN_UOP_DONE: pes_evt_index = {1'b1, `PES_IX_UOP_DONE};
            `PES_EVN_UOP_SPEC: pes_evt_index = {1'b1, `PES_IX_UOP_SPEC};
            `PES_EVN_SLOT_BE: pes_evt_index = {1'b1, `PES_IX_SLOT_BE};
            `PES_EVN_SLOT_FE: pes_evt_index = {1'b1, `PES_IX_SLOT_FE};
            `PES_EVN_SLOT_ANY: pes_evt_index = {1'b1, `PES_IX_SLOT_ANY};
            default: pes_evt_index = 7'h00;
        endcase
    end
endfunction

reg [`PES_IDX_W:0] hit;

// unknown numbers count nothing
always @* begin
    hit = pes_evt_index(evt_num_i);
    known_o = hit[`PES_IDX_W];
    inc_o = 3'h0;
    if (hit[`PES_IDX_W]) begin
        inc_o = src_inc_i[hit[`PES_IDX_W-1:0]*`PES_INC_W +: `PES_INC_W];
    end
end

endmodule

/* rtl/pes_top.v */
// performance event sources and counter bank of one processing element
`timescale 1ns/10ps
`include "pes_defs.vh"

// What this block does
// - retired instructions and cycles are countable events
// - local cache and memory access events provided
// - last level read and read miss events
// - slow miss events for data and instruction
// - read only cache and memory access events
// - only local caches and last level covered
// - translation cache access and walk events
// - demand only variants of cache and walk
// - demand events use recommended numbers
// - frontend, backend and any stall cycles
// - memory stall cycle event provided
// - micro operations retired and speculated counted
// - slot stall events backend, frontend, any
// - slot stall step capped, slot count readable
// - events counted by their own element
// - six programmable counters plus cycle counter
// - overflow flags drive private interrupt line through their enable bits and a flop
module pes_top (
    input wire sys_clk_i,
    input wire srst_i,
    input wire [`PES_NUM_PULSE-1:0] evt_pulse_i,
    input wire stall_frontend_i,
    input wire stall_backend_i,
    input wire stall_mem_i,
    input wire [`PES_INC_W-1:0] uop_arch_done_cnt_i,
    input wire [`PES_INC_W-1:0] uop_speculated_cnt_i,
    input wire [`PES_INC_W-1:0] slot_stall_be_cnt_i,
    input wire [`PES_INC_W-1:0] slot_stall_fe_cnt_i,
    input wire [`PES_NUM_CNT*`PES_EVN_W-1:0] cnt_evt_sel_i,
    input wire [`PES_NUM_CNT-1:0] cnt_en_i,
    input wire [`PES_NUM_CNT-1:0] cnt_clr_i,
    input wire cyc_en_i,
    input wire cyc_clr_i,
    input wire [`PES_NUM_CNT-1:0] ovf_clr_i,
    input wire [`PES_NUM_CNT:0] ovf_irq_en_i,
    output wire [`PES_NUM_CNT*`PES_CNT_W-1:0] cnt_val_o,
    output reg [`PES_CYC_W-1:0] cyc_val_o,
    output reg [`PES_NUM_CNT:0] ovf_flag_o,
    output reg [`PES_NUM_CNT-1:0] cnt_evt_known_o,
    output reg private_periph_irq_o,
    output reg [`PES_SLOTS_W-1:0] slot_count_o
);

// ****************************************
// saturating cap for slot counts
// ****************************************
function [`PES_INC_W-1:0] pes_slot_cap;
    input [`PES_INC_W:0] amt;
    begin
        if (amt > {1'b0, `PES_SLOTS}) begin
            pes_slot_cap = `PES_SLOTS;
        end else begin
            pes_slot_cap = amt[`PES_INC_W-1:0];
        end
    end
endfunction

// ****************************************
// one event bit as an increment
// ****************************************
function [`PES_INC_W-1:0] pes_bit_inc;
    input flag;
    begin
        pes_bit_inc = {2'b00, flag};
    end
endfunction

// ****************************************
// input stage
// ****************************************
reg [`PES_NUM_PULSE-1:0] pulse_reg;
reg stall_fe_reg;
reg stall_be_reg;
reg stall_any_reg;
reg stall_mem_reg;
reg [`PES_INC_W-1:0] uop_done_reg;
reg [`PES_INC_W-1:0] uop_spec_reg;
reg [`PES_INC_W-1:0] slot_be_reg;
reg [`PES_INC_W-1:0] slot_fe_reg;
reg [`PES_INC_W-1:0] slot_any_reg;
reg [`PES_INC_W-1:0] slot_be_next;
reg [`PES_INC_W-1:0] slot_fe_next;
reg [`PES_INC_W-1:0] slot_any_next;
reg [`PES_INC_W:0] slot_sum_next;
reg stall_any_next;
reg stall_mem_next;

// one flop per source, so every event reaches its counter with one latency
// only this element's own sources are sampled here
always @(posedge sys_clk_i) begin
    if (srst_i) begin
        pulse_reg <= 31'h0000_0000;
    end else begin
        pulse_reg <= evt_pulse_i;
    end
end

always @(posedge sys_clk_i) begin
    if (srst_i) begin
        stall_fe_reg <= 1'b0;
        stall_be_reg <= 1'b0;
        stall_any_reg <= 1'b0;
        stall_mem_reg <= 1'b0;
    end else begin
        stall_fe_reg <= stall_frontend_i;
        stall_be_reg <= stall_backend_i;
        stall_any_reg <= stall_any_next;
        stall_mem_reg <= stall_mem_next;
    end
end

// any stall is the union; a memory stall outside a backend stall is dropped
always @* begin
    stall_any_next = stall_frontend_i | stall_backend_i;
    stall_mem_next = stall_mem_i & stall_backend_i;
end

always @(posedge sys_clk_i) begin
    if (srst_i) begin
        uop_done_reg <= 3'h0;
        uop_spec_reg <= 3'h0;
    end else begin
        uop_done_reg <= uop_arch_done_cnt_i;
        uop_spec_reg <= uop_speculated_cnt_i;
    end
end

// ****************************************
// slot stall accounting
// ****************************************
always @* begin
    slot_be_next = pes_slot_cap({1'b0, slot_stall_be_cnt_i});
    slot_fe_next = pes_slot_cap({1'b0, slot_stall_fe_cnt_i});
    slot_sum_next = {1'b0, slot_be_next} + {1'b0, slot_fe_next};
    slot_any_next = pes_slot_cap(slot_sum_next);
end

always @(posedge sys_clk_i) begin
    if (srst_i) begin
        slot_be_reg <= 3'h0;
        slot_fe_reg <= 3'h0;
        slot_any_reg <= 3'h0;
    end else begin
        slot_be_reg <= slot_be_next;
        slot_fe_reg <= slot_fe_next;
        slot_any_reg <= slot_any_next;
    end
end

// slot count field as software would read it
always @(posedge sys_clk_i) begin
    if (srst_i) begin
        slot_count_o <= 4'h0;
    end else begin
        slot_count_o <= {1'b0, `PES_SLOTS};
    end
end

// ****************************************
// source increment bus
// ****************************************
wire [`PES_NUM_SRC*`PES_INC_W-1:0] src_inc;

// pulse bits: 0 instructions, 1 to 6 access, 7 and 8 last level,
// 9 and 14 to 17 slow misses, 10 to 13 reads, 18 to 21 translation,
// 22 to 30 demand only; caches that are not local have no bit at all
genvar gp;
generate
    for (gp = 0; gp < `PES_NUM_PULSE; gp = gp + 1) begin : g_pulse
        assign src_inc[gp*`PES_INC_W +: `PES_INC_W] = pes_bit_inc(pulse_reg[gp]);
    end
endgenerate

// level sources add one a cycle, count sources add their value
assign src_inc[`PES_IX_CYCLES*`PES_INC_W +: `PES_INC_W] = 3'h1;
assign src_inc[`PES_IX_STALL_FE*`PES_INC_W +: `PES_INC_W] = pes_bit_inc(stall_fe_reg);
assign src_inc[`PES_IX_STALL_BE*`PES_INC_W +: `PES_INC_W] = pes_bit_inc(stall_be_reg);
assign src_inc[`PES_IX_STALL_ANY*`PES_INC_W +: `PES_INC_W] = pes_bit_inc(stall_any_reg);
assign src_inc[`PES_IX_STALL_MEM*`PES_INC_W +: `PES_INC_W] = pes_bit_inc(stall_mem_reg);
assign src_inc[`PES_IX_UOP_DONE*`PES_INC_W +: `PES_INC_W] = uop_done_reg;
assign src_inc[`PES_IX_UOP_SPEC*`PES_INC_W +: `PES_INC_W] = uop_spec_reg;
assign src_inc[`PES_IX_SLOT_BE*`PES_INC_W +: `PES_INC_W] = slot_be_reg;
assign src_inc[`PES_IX_SLOT_FE*`PES_INC_W +: `PES_INC_W] = slot_fe_reg;
assign src_inc[`PES_IX_SLOT_ANY*`PES_INC_W +: `PES_INC_W] = slot_any_reg;

// ****************************************
// programmable counters
// ****************************************
wire [`PES_NUM_CNT-1:0] cnt_wrap;
wire [`PES_NUM_CNT-1:0] sel_known;

// a counter set to an unknown number stands still
genvar gc;
generate
    for (gc = 0; gc < `PES_NUM_CNT; gc = gc + 1) begin : g_cnt
        wire [`PES_INC_W-1:0] inc;

        pes_evt_sel u_sel (
            .evt_num_i(cnt_evt_sel_i[gc*`PES_EVN_W +: `PES_EVN_W]),
            .src_inc_i(src_inc),
            .inc_o(inc),
            .known_o(sel_known[gc])
        );

        pes_counter u_cnt (
            .sys_clk_i(sys_clk_i),
            .srst_i(srst_i),
            .en_i(cnt_en_i[gc]),
            .clr_i(cnt_clr_i[gc]),
            .inc_i(inc),
            .val_o(cnt_val_o[gc*`PES_CNT_W +: `PES_CNT_W]),
            .wrap_o(cnt_wrap[gc])
        );
    end
endgenerate

// tells software whether the chosen number is served here
always @(posedge sys_clk_i) begin
    if (srst_i) begin
        cnt_evt_known_o <= 6'h00;
    end else begin
        cnt_evt_known_o <= sel_known;
    end
end

// ****************************************
// dedicated cycle counter
// ****************************************
reg cyc_wrap_reg;
reg [`PES_CYC_W-1:0] cyc_val_next;
reg cyc_wrap_next;
wire [`PES_CYC_W:0] cyc_sum;

assign cyc_sum = {1'b0, cyc_val_o} + 65'h1;

// clear beats counting; the wrap bit lives for one cycle only
always @* begin
    cyc_val_next = cyc_val_o;
    cyc_wrap_next = 1'b0;
    if (cyc_clr_i) begin
        cyc_val_next = 64'h0;
    end else if (cyc_en_i) begin
        cyc_val_next = cyc_sum[`PES_CYC_W-1:0];
        cyc_wrap_next = cyc_sum[`PES_CYC_W];
    end
end

always @(posedge sys_clk_i) begin
    if (srst_i) begin
        cyc_val_o <= 64'h0;
        cyc_wrap_reg <= 1'b0;
    end else begin
        cyc_val_o <= cyc_val_next;
        cyc_wrap_reg <= cyc_wrap_next;
    end
end

// ****************************************
// overflow flags and interrupt line
// ****************************************
wire [`PES_NUM_CNT:0] wrap_all;
wire [`PES_NUM_CNT:0] clr_all;
wire [`PES_NUM_CNT:0] ovf_flag_next;

assign wrap_all = {cyc_wrap_reg, cnt_wrap};
assign clr_all = {cyc_clr_i, ovf_clr_i};

// a wrap in the clearing cycle keeps its flag, so no overflow is lost
genvar gf;
generate
    for (gf = 0; gf <= `PES_NUM_CNT; gf = gf + 1) begin : g_flag
        assign ovf_flag_next[gf] = wrap_all[gf] | (ovf_flag_o[gf] & ~clr_all[gf]);
    end
endgenerate

always @(posedge sys_clk_i) begin
    if (srst_i) begin
        ovf_flag_o <= 7'h00;
    end else begin
        ovf_flag_o <= ovf_flag_next;
    end
end

// ****************************************
// interrupt line
// ****************************************
wire irq_next;

// each flag reaches the line only through its own enable bit
assign irq_next = |(ovf_flag_o & ovf_irq_en_i);

// line is a flop fed only by the flags and their enables
always @(posedge sys_clk_i) begin
    if (srst_i) begin
        private_periph_irq_o <= 1'b0;
    end else begin
        private_periph_irq_o <= irq_next;
    end
end

endmodule

/* sim/pes_pipe_model.sv */
// behavioural pipeline, cache and translation event source
`timescale 1ns/10ps
`include "pes_defs.vh"
module pes_pipe_model (
    input wire sys_clk_i,
    output logic [`PES_NUM_PULSE-1:0] evt_pulse_o,
    output logic stall_fe_o,
    output logic stall_be_o,
    output logic stall_mem_o,
    output logic [`PES_INC_W-1:0] uop_done_o,
    output logic [`PES_INC_W-1:0] uop_spec_o,
    output logic [`PES_INC_W-1:0] slot_be_o,
    output logic [`PES_INC_W-1:0] slot_fe_o
);
    // ****************
    // event drivers
    // ****************
    initial begin
        evt_pulse_o = '0;
        {stall_fe_o, stall_be_o, stall_mem_o} = 3'h0;
        {uop_done_o, uop_spec_o, slot_be_o, slot_fe_o} = 12'h000;
    end
    // n occurrences, one cycle each, back to back
    task pulse(input int idx, input int n);
        @(negedge sys_clk_i);
        evt_pulse_o[idx] = 1'b1;
        repeat (n) @(negedge sys_clk_i);
        evt_pulse_o[idx] = 1'b0;
    endtask
    task stall(input logic fe, input logic be, input logic mem, input int n);
        @(negedge sys_clk_i);
        {stall_fe_o, stall_be_o, stall_mem_o} = {fe, be, mem};
        repeat (n) @(negedge sys_clk_i);
        {stall_fe_o, stall_be_o, stall_mem_o} = 3'h0;
    endtask
    task counts(input logic [2:0] ud, input logic [2:0] us, input logic [2:0] sb,
                input logic [2:0] sf);
        @(negedge sys_clk_i);
        {uop_done_o, uop_spec_o, slot_be_o, slot_fe_o} = {ud, us, sb, sf};
        @(negedge sys_clk_i);
        {uop_done_o, uop_spec_o, slot_be_o, slot_fe_o} = 12'h000;
    endtask
endmodule

/* sim/pes_top_monitor.sv */
// assertions on the counter bank ports
`timescale 1ns/10ps
`include "pes_defs.vh"
module pes_top_monitor (
    input wire sys_clk_i,
    input wire srst_i,
    input wire [`PES_NUM_CNT-1:0] cnt_en_i,
    input wire [`PES_NUM_CNT-1:0] cnt_clr_i,
    input wire cyc_en_i,
    input wire cyc_clr_i,
    input wire [`PES_NUM_CNT-1:0] ovf_clr_i,
    input wire [`PES_NUM_CNT:0] ovf_irq_en_i,
    input wire [`PES_NUM_CNT*`PES_CNT_W-1:0] cnt_val_o,
    input wire [`PES_CYC_W-1:0] cyc_val_o,
    input wire [`PES_NUM_CNT:0] ovf_flag_o,
    input wire private_periph_irq_o,
    input wire [`PES_SLOTS_W-1:0] slot_count_o
);
    // ****************
    // properties
    // ****************
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    property p_irq;
        private_periph_irq_o == $past(|(ovf_flag_o & ovf_irq_en_i));
    endproperty
    a_irq: assert property (p_irq) else $error("irq not flags and enables");
    property p_cyc_step;
        cyc_en_i && !cyc_clr_i |=> cyc_val_o == $past(cyc_val_o) + 64'h1;
    endproperty
    a_cyc_step: assert property (p_cyc_step) else $error("cycle count step");
    property p_cyc_clr;
        cyc_clr_i |=> cyc_val_o == 64'h0;
    endproperty
    a_cyc_clr: assert property (p_cyc_clr) else $error("cycle count clear");
    property p_slots;
        !srst_i |=> slot_count_o == 4'h4;
    endproperty
    a_slots: assert property (p_slots) else $error("slot count field");
    property p_clr;
        cnt_clr_i[0] |=> cnt_val_o[31:0] == 32'h0;
    endproperty
    a_clr: assert property (p_clr) else $error("counter clear");
    property p_hold;
        !cnt_en_i[3] && !cnt_clr_i[3] |=> $stable(cnt_val_o[127:96]);
    endproperty
    a_hold: assert property (p_hold) else $error("disabled counter moved");
    property p_step;
        !cnt_clr_i[0] |=> (cnt_val_o[31:0] - $past(cnt_val_o[31:0])) <= 32'h7;
    endproperty
    a_step: assert property (p_step) else $error("counter step too large");
    property p_ovf;
        !ovf_flag_o[0] && cnt_val_o[31:0] >= $past(cnt_val_o[31:0]) |=> !ovf_flag_o[0];
    endproperty
    a_ovf: assert property (p_ovf) else $error("flag without wrap");
endmodule
bind pes_top pes_top_monitor pes_top_monitor_i (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .cnt_en_i(cnt_en_i), .cnt_clr_i(cnt_clr_i), .cyc_en_i(cyc_en_i), .cyc_clr_i(cyc_clr_i),
    .ovf_clr_i(ovf_clr_i), .ovf_irq_en_i(ovf_irq_en_i), .cnt_val_o(cnt_val_o),
    .cyc_val_o(cyc_val_o), .ovf_flag_o(ovf_flag_o),
    .private_periph_irq_o(private_periph_irq_o), .slot_count_o(slot_count_o));

/* sim/tb.sv */
// self-checking bench for the performance event sources
`timescale 1ns/10ps
`include "pes_defs.vh"
module tb;
    // ****************
    // signals and helpers
    // ****************
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [95:0] cnt_evt_sel_i = '0;
    logic [5:0] cnt_en_i = 6'h3f;
    logic [5:0] cnt_clr_i = 6'h00;
    logic cyc_en_i = 1'b0;
    logic cyc_clr_i = 1'b0;
    logic [5:0] ovf_clr_i = 6'h00;
    logic [6:0] ovf_irq_en_i = 7'h7f;
    wire [30:0] evt;
    wire sfe, sbe, smem;
    wire [2:0] udone, uspec, sl_be, sl_fe;
    wire [191:0] cnt_val_o;
    wire [63:0] cyc_val_o;
    wire [6:0] ovf_flag_o;
    wire [5:0] cnt_evt_known_o;
    wire private_periph_irq_o;
    wire [3:0] slot_count_o;
    int n_mismatch = 0;
    int num_checks = 0;
    logic [15:0] evn [31] = '{16'h0008, 16'h0004, 16'h0013, 16'h0014, 16'h0016, 16'h0027,
        16'h002b, 16'h0036, 16'h0037, 16'h0039, 16'h0040, 16'h0050, 16'h0066, 16'h00a0,
        16'h4006, 16'h4009, 16'h400a, 16'h400b, 16'h0025, 16'h0026, 16'h0034, 16'h0035,
        16'h8130, 16'h8131, 16'h813c, 16'h813d, 16'h8140, 16'h8141, 16'h8148, 16'h8149,
        16'h8150};
    pes_pipe_model pipe_i (.sys_clk_i(sys_clk_i), .evt_pulse_o(evt), .stall_fe_o(sfe),
        .stall_be_o(sbe), .stall_mem_o(smem), .uop_done_o(udone), .uop_spec_o(uspec),
        .slot_be_o(sl_be), .slot_fe_o(sl_fe));
    pes_top pes_top_i (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .evt_pulse_i(evt),
        .stall_frontend_i(sfe), .stall_backend_i(sbe), .stall_mem_i(smem),
        .uop_arch_done_cnt_i(udone), .uop_speculated_cnt_i(uspec),
        .slot_stall_be_cnt_i(sl_be), .slot_stall_fe_cnt_i(sl_fe),
        .cnt_evt_sel_i(cnt_evt_sel_i), .cnt_en_i(cnt_en_i), .cnt_clr_i(cnt_clr_i),
        .cyc_en_i(cyc_en_i), .cyc_clr_i(cyc_clr_i), .ovf_clr_i(ovf_clr_i),
        .ovf_irq_en_i(ovf_irq_en_i), .cnt_val_o(cnt_val_o), .cyc_val_o(cyc_val_o),
        .ovf_flag_o(ovf_flag_o), .cnt_evt_known_o(cnt_evt_known_o),
        .private_periph_irq_o(private_periph_irq_o), .slot_count_o(slot_count_o));
    task chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function logic [31:0] cnt(input int n);
        return cnt_val_o[32*n +: 32];
    endfunction
    task sel(input int n, input logic [15:0] num);
        cnt_evt_sel_i[16*n +: 16] = num;
    endtask
    task clear_all;
        @(negedge sys_clk_i);
        cnt_clr_i = 6'h3f;
        @(negedge sys_clk_i);
        cnt_clr_i = 6'h00;
    endtask
    task settle;
        repeat (2) @(negedge sys_clk_i);
    endtask
    task finish_test;
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ****************
    // scenarios
    // ****************
    // each event number counts its own source only
    task s_events;
        for (int i = 0; i < 31; i++) begin
            sel(0, evn[i]);
            sel(1, evn[(i + 1) % 31]);
            clear_all;
            pipe_i.pulse(i, 2);
            pipe_i.pulse((i + 30) % 31, 1);
            settle;
            chk("evt_count", cnt(0), 2);
            chk("evt_known", cnt_evt_known_o[0], 1);
            chk("evt_other", cnt(1), 0);
        end
    endtask
    task s_stall;
        logic [31:0] c0;
        sel(0, 16'h0023);
        sel(1, 16'h0024);
        sel(2, 16'h003c);
        sel(3, 16'h4005);
        sel(4, 16'h0011);
        clear_all;
        pipe_i.stall(1'b1, 1'b0, 1'b0, 2);
        pipe_i.stall(1'b0, 1'b1, 1'b1, 3);
        pipe_i.stall(1'b0, 1'b0, 1'b1, 2);
        pipe_i.stall(1'b1, 1'b1, 1'b0, 1);
        settle;
        chk("stall_fe", cnt(0), 3);
        chk("stall_be", cnt(1), 4);
        chk("stall_any", cnt(2), 6);
        chk("stall_mem", cnt(3), 3);
        c0 = cnt(4);
        repeat (10) @(negedge sys_clk_i);
        chk("cycle_evt", cnt(4) - c0, 10);
        chk("cycle_known", cnt_evt_known_o[4], 1);
    endtask
    task s_slots;
        sel(0, 16'h003a);
        sel(1, 16'h003b);
        sel(2, 16'h003d);
        sel(3, 16'h003e);
        sel(4, 16'h003f);
        sel(5, 16'h0001);
        clear_all;
        pipe_i.counts(3'h7, 3'h5, 3'h3, 3'h3);
        pipe_i.counts(3'h1, 3'h2, 3'h7, 3'h0);
        settle;
        chk("uop_done", cnt(0), 8);
        chk("uop_spec", cnt(1), 7);
        chk("slot_be", cnt(2), 7);
        chk("slot_fe", cnt(3), 3);
        chk("slot_any", cnt(4), 8);
        chk("unknown_cnt", cnt(5), 0);
        chk("unknown_known", cnt_evt_known_o[5], 0);
        chk("slot_field", slot_count_o, 4);
    endtask
    task s_ctrl;
        for (int n = 0; n < 6; n++) sel(n, 16'h0008);
        cnt_en_i = 6'h37;
        clear_all;
        pipe_i.pulse(0, 3);
        settle;
        for (int n = 0; n < 6; n++) chk("cnt_enable", cnt(n), (n == 3) ? 0 : 3);
        cnt_en_i = 6'h3f;
        fork
            pipe_i.pulse(0, 1);
            begin
                repeat (2) @(negedge sys_clk_i);
                cnt_clr_i = 6'h01;
                @(negedge sys_clk_i);
                cnt_clr_i = 6'h00;
            end
        join
        settle;
        chk("clr_wins", cnt(0), 0);
        chk("cnt_kept", cnt(1), 4);
        cyc_clr_i = 1'b1;
        @(negedge sys_clk_i);
        cyc_clr_i = 1'b0;
        cyc_en_i = 1'b1;
        repeat (10) @(negedge sys_clk_i);
        cyc_en_i = 1'b0;
        settle;
        chk("cycles", cyc_val_o, 10);
        chk("ovf_flags", ovf_flag_o, 0);
        chk("irq_idle", private_periph_irq_o, 0);
    endtask
    // ****************
    // sequence
    // ****************
    initial begin
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        #1000000;
        n_mismatch++;
        finish_test;
    end
    initial begin
        repeat (8) @(negedge sys_clk_i);
        srst_i = 1'b0;
        s_events;
        s_stall;
        s_slots;
        s_ctrl;
        finish_test;
    end
endmodule
